// ### src/command_evaluator.sv
// Purpose: Matches received frames and steps or toggles the shared LED level.
// Assumes: Frame and repeat strobes are one-cycle pulses.
// Notes:   A repeat reapplies the last accepted command.
module command_evaluator (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        frame_vld,
  input  wire logic [31:0] frame,
  input  wire logic        repeat_vld,
  input  wire logic [15:0] addr_code,
  input  wire logic [7:0]  cmd_a,
  input  wire logic [7:0]  cmd_b,
  output logic      [7:0]  level,
  output logic             accept,
  output logic             reject
);
  logic [2:0]         step_q;
  logic [7:0]         level_q;
  logic               accept_q;
  logic               reject_q;
  irx_pkg::last_cmd_t last_q;

  function automatic logic [7:0] step_level(input logic [2:0] s);
    case (s)
      3'h0:    step_level = irx_pkg::LEVEL_OFF;
      3'h1:    step_level = irx_pkg::LEVEL_LOW;
      3'h2:    step_level = irx_pkg::LEVEL_MID;
      3'h3:    step_level = irx_pkg::LEVEL_MAX;
      3'h4:    step_level = irx_pkg::LEVEL_MID;
      default: step_level = irx_pkg::LEVEL_LOW;
    endcase
  endfunction : step_level

  // Custom code low 16 bits, data code next byte
  wire       custom_ok = (frame[15:0] == addr_code);
  wire       is_a      = custom_ok && (frame[23:16] == cmd_a);
  wire       is_b      = custom_ok && !is_a && (frame[23:16] == cmd_b);
  wire       do_a      = (frame_vld && is_a) || (repeat_vld && last_q == irx_pkg::last_a);
  wire       do_b      = (frame_vld && is_b) || (repeat_vld && last_q == irx_pkg::last_b);
  wire [2:0] step_nxt  = (step_q == irx_pkg::STEP_LAST) ? 3'h0 : step_q + 3'h1;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      step_q  <= 3'h0;
      level_q <= irx_pkg::LEVEL_OFF;
    end else if (do_a) begin
      step_q  <= step_nxt;
      level_q <= step_level(step_nxt);
    end else if (do_b) begin
      level_q <= (level_q == irx_pkg::LEVEL_OFF) ? irx_pkg::LEVEL_MAX : irx_pkg::LEVEL_OFF;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      last_q   <= irx_pkg::last_none;
      accept_q <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      accept_q <= frame_vld && (is_a || is_b);
      reject_q <= frame_vld && !(is_a || is_b);
      if (frame_vld && is_a) begin
        last_q <= irx_pkg::last_a;
      end else if (frame_vld && is_b) begin
        last_q <= irx_pkg::last_b;
      end
    end
  end

  assign level  = level_q;
  assign accept = accept_q;
  assign reject = reject_q;

  level_step_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    do_a && step_q == 3'h2 |=> level_q == irx_pkg::LEVEL_MAX ##1 1)
    else $error("step sequence did not reach maximum");
  level_toggle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !do_a && do_b |=> level_q != $past(level_q) && (level_q == 8'h00 || level_q == 8'hFF))
    else $error("second command did not toggle level");
  code_reject_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    frame_vld && !custom_ok |=> reject_q && !accept_q && $stable(level_q))
    else $error("frame with wrong custom code changed level");
  cmd_a_cov: cover property (@(posedge clk_sys) frame_vld && is_a);
  cmd_b_cov: cover property (@(posedge clk_sys) frame_vld && is_b);

endmodule : command_evaluator

// ### src/ir_pulse_distance_receiver.sv
// Purpose: Pulse-distance IR frame receiver driving a shared LED level over APB control.
// Assumes: ir_input_pin is asynchronous; APB slave, 32-bit data.
// Notes:   Leader states advance only on the sampling tick; the frame state also leaves on the last bit.
// Functional notes
// - Width counter counts at system clock, starts on rise, captures on fall.
// - Width capture stays masked after reset until bit reception begins.
// - Sampling tick runs at 100 us intervals once software starts it.
// - Leader detection has four states: fall, rise, high width check, frame.
// - Normal leader enters frame state, ignores ticks, starts width measurement; here ticks still count toward the frame timeout.
// - Width above threshold stores one, below stores zero.
// - After 32 bits: mask capture, stop channel, return to fall wait, evaluate.
// - Accept frame only if custom code and one of two data codes match.
// - First command steps level through 0, 85, 170, 255, 170, 85 repeatedly.
// - Second command toggles level between 0 and 255.
// - Leader low period must last at least 7 ms.
// - High at least 3 ms is a normal leader, shorter is a repeat; here a high beyond 6 ms returns to the fall wait.
// - Bit threshold is 1 ms.
// - Repeat leader reapplies the level change without data bits.
//
// Chosen here: register access over APB and the register addresses.
module ir_pulse_distance_receiver #(
  parameter int TICK_CYCLES       = irx_pkg::TICK_CYCLES,
  parameter int BIT_THRESH_CYCLES = irx_pkg::BIT_THRESH_CYCLES,
  parameter int WIDTH_W           = 20
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ir_input_pin,
  output logic             irq,
  output logic      [7:0]  led_level_a,
  output logic      [7:0]  led_level_b,
  output logic      [7:0]  led_level_c
);
  localparam int TCW = $clog2(TICK_CYCLES + 1);
  localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);
  localparam int LW = irx_pkg::LD_CNT_W;
  localparam logic [LW-1:0] LOW_T   = LW'(irx_pkg::LOW_TICKS);
  localparam logic [LW-1:0] HIGH_T  = LW'(irx_pkg::HIGH_TICKS);
  localparam logic [LW-1:0] HMAX_T  = LW'(irx_pkg::HIGH_MAX_TICKS);
  localparam logic [LW-1:0] TOUT_T  = LW'(irx_pkg::TIMEOUT_TICKS);
  localparam logic [LW-1:0] LD_MAX  = '1;
  localparam logic [4:0]    LAST_BIT = 5'(irx_pkg::FRAME_BITS - 1);

  width_if #(.WIDTH_W(WIDTH_W)) wif ();

  // Pin synchroniser and edge detect
  logic ir_m_q;
  logic ir_s_q;
  logic ir_d_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ir_m_q <= 1'b1;
      ir_s_q <= 1'b1;
      ir_d_q <= 1'b1;
    end else begin
      ir_m_q <= ir_input_pin;
      ir_s_q <= ir_m_q;
      ir_d_q <= ir_s_q;
    end
  end
  wire ir_rise = ir_s_q && !ir_d_q;
  wire ir_fall = !ir_s_q && ir_d_q;

  // APB registers
  logic                 tick_run_q;
  logic [15:0]          addr_code_q;
  logic [7:0]           cmd_a_q;
  logic [7:0]           cmd_b_q;
  logic [irx_pkg::ST_W-1:0] status_q;
  logic [irx_pkg::ST_W-1:0] mask_q;
  logic [31:0]          last_frame_q;
  logic                 pready_q;
  logic [31:0]          prdata_q;
  logic                 pslverr_q;
  logic                 irq_q;

  // Sampling tick
  logic [TCW-1:0] tick_cnt_q;
  logic           tick_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !tick_run_q) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + 1'b1;
      tick_q     <= (tick_cnt_q == TICK_LAST);
    end
  end

  // Leader detection
  irx_pkg::leader_state_t state_q;
  irx_pkg::leader_state_t state_d;
  logic [LW-1:0] ld_cnt_q;
  logic [LW-1:0] ld_cnt_d;
  logic          meas_en_q;
  logic          meas_en_d;
  logic          rep_d;
  logic          tout_d;
  logic          rep_q;
  logic          tout_q;
  logic          frame_vld_q;
  logic [4:0]    bit_cnt_q;
  logic [31:0]   frame_q;

  wire [LW-1:0] ld_inc   = (ld_cnt_q == LD_MAX) ? ld_cnt_q : ld_cnt_q + 1'b1;
  wire          last_bit = wif.bit_vld && (bit_cnt_q == LAST_BIT);

  always_comb begin
    state_d   = state_q;
    ld_cnt_d  = ld_cnt_q;
    meas_en_d = meas_en_q;
    rep_d     = 1'b0;
    tout_d    = 1'b0;
    case (state_q)
      irx_pkg::wait_leader_fall: begin
        if (tick_q && !ir_s_q) begin
          state_d  = irx_pkg::wait_leader_rise;
          ld_cnt_d = '0;
        end
      end
      irx_pkg::wait_leader_rise: begin
        if (tick_q && !ir_s_q) begin
          ld_cnt_d = ld_inc;
        end else if (tick_q && ld_cnt_q >= LOW_T) begin
          state_d  = irx_pkg::check_leader_high_width;
          ld_cnt_d = '0;
        end else if (tick_q) begin
          state_d  = irx_pkg::wait_leader_fall;
        end
      end
      irx_pkg::check_leader_high_width: begin
        if (tick_q && ir_s_q && ld_cnt_q >= HMAX_T) begin
          state_d  = irx_pkg::wait_leader_fall;
        end else if (tick_q && ir_s_q) begin
          ld_cnt_d = ld_inc;
        end else if (tick_q && ld_cnt_q >= HIGH_T) begin
          state_d   = irx_pkg::receive_frame_bits;
          ld_cnt_d  = '0;
          meas_en_d = 1'b1;
        end else if (tick_q) begin
          state_d  = irx_pkg::wait_leader_fall;
          rep_d    = 1'b1;
        end
      end
      irx_pkg::receive_frame_bits: begin
        if (last_bit) begin
          state_d   = irx_pkg::wait_leader_fall;
          meas_en_d = 1'b0;
        end else if (tick_q && ld_cnt_q >= TOUT_T) begin
          state_d   = irx_pkg::wait_leader_fall;
          meas_en_d = 1'b0;
          tout_d    = 1'b1;
        end else if (tick_q) begin
          ld_cnt_d  = ld_inc;
        end
      end
      default: begin
        state_d   = irx_pkg::wait_leader_fall;
        meas_en_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q   <= irx_pkg::wait_leader_fall;
      ld_cnt_q  <= '0;
      meas_en_q <= 1'b0;
      rep_q     <= 1'b0;
      tout_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      ld_cnt_q  <= ld_cnt_d;
      meas_en_q <= meas_en_d;
      rep_q     <= rep_d;
      tout_q    <= tout_d;
    end
  end

  // Bit assembly, LSB first
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bit_cnt_q    <= '0;
      frame_q      <= '0;
      frame_vld_q  <= 1'b0;
      last_frame_q <= '0;
    end else begin
      frame_vld_q <= last_bit && meas_en_q;
      if (!meas_en_q) begin
        bit_cnt_q <= '0;
      end else if (wif.bit_vld) begin
        bit_cnt_q <= bit_cnt_q + 5'h1;
        frame_q   <= {wif.bit_val, frame_q[31:1]};
      end
      if (frame_vld_q) begin
        last_frame_q <= frame_q;
      end
    end
  end

  assign wif.en   = meas_en_q;
  assign wif.rise = ir_rise;
  assign wif.fall = ir_fall;

  width_meter #(.WIDTH_W(WIDTH_W), .BIT_THRESH_CYCLES(BIT_THRESH_CYCLES)) u_meter (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .wif     (wif)
  );

  logic [7:0] level;
  logic       accept;
  logic       reject;
  command_evaluator u_eval (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .frame_vld  (frame_vld_q),
    .frame      (frame_q),
    .repeat_vld (rep_q),
    .addr_code  (addr_code_q),
    .cmd_a      (cmd_a_q),
    .cmd_b      (cmd_b_q),
    .level      (level),
    .accept     (accept),
    .reject     (reject)
  );

  // APB decode
  wire acc      = psel && penable;
  wire wr_en    = acc && pwrite && pready_q;
  wire pready_d = acc && !pready_q;
  wire hit_ctrl = (paddr == irx_pkg::OFS_CTRL);
  wire hit_addr = (paddr == irx_pkg::OFS_ADDR_CODE);
  wire hit_cmd  = (paddr == irx_pkg::OFS_CMD_CODES);
  wire hit_stat = (paddr == irx_pkg::OFS_STATUS);
  wire hit_mask = (paddr == irx_pkg::OFS_IRQ_MASK);
  wire hit_frm  = (paddr == irx_pkg::OFS_FRAME);
  wire hit_st   = (paddr == irx_pkg::OFS_STATE);
  wire hit_any  = hit_ctrl | hit_addr | hit_cmd | hit_stat | hit_mask | hit_frm | hit_st;
  wire [irx_pkg::ST_W-1:0] st_set = {tout_q, reject, rep_q, accept};
  wire [irx_pkg::ST_W-1:0] st_clr = (wr_en && hit_stat) ? pwdata[irx_pkg::ST_W-1:0] : '0;
  wire [31:0] rd_mux =
      hit_ctrl ? {31'h0, tick_run_q} :
      hit_addr ? {16'h0, addr_code_q} :
      hit_cmd  ? {16'h0, cmd_b_q, cmd_a_q} :
      hit_stat ? {28'h0, status_q} :
      hit_mask ? {28'h0, mask_q} :
      hit_frm  ? last_frame_q :
      hit_st   ? {16'h0, 1'b0, meas_en_q, state_q, 4'h0, level} : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tick_run_q  <= 1'b0;
      addr_code_q <= irx_pkg::ADDR_CODE_RST;
      cmd_a_q     <= irx_pkg::CMD_A_RST;
      cmd_b_q     <= irx_pkg::CMD_B_RST;
      mask_q      <= '0;
    end else if (wr_en) begin
      if (hit_ctrl) tick_run_q <= pwdata[irx_pkg::CTRL_TICK_RUN];
      if (hit_addr) addr_code_q <= pwdata[15:0];
      if (hit_cmd) {cmd_b_q, cmd_a_q} <= pwdata[15:0];
      if (hit_mask) mask_q <= pwdata[irx_pkg::ST_W-1:0];
    end
  end

  // Set wins over write-one-clear
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      status_q  <= '0;
      irq_q     <= 1'b0;
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      status_q  <= (status_q & ~st_clr) | st_set;
      irq_q     <= |(((status_q & ~st_clr) | st_set) & mask_q);
      pready_q  <= pready_d;
      prdata_q  <= (pready_d && !pwrite) ? rd_mux : 32'h0;
      pslverr_q <= pready_d && !hit_any;
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign irq         = irq_q;
  assign led_level_a = level;
  assign led_level_b = level;
  assign led_level_c = level;

  low_period_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_q == irx_pkg::wait_leader_rise && state_d == irx_pkg::check_leader_high_width
    |-> ld_cnt_q >= LOW_T)
    else $error("leader low period accepted too short");
  normal_leader_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_q == irx_pkg::check_leader_high_width && tick_q && !ir_s_q && ld_cnt_q >= HIGH_T
    |=> state_q == irx_pkg::receive_frame_bits && meas_en_q)
    else $error("normal leader did not start frame reception");
  repeat_lead_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_q == irx_pkg::check_leader_high_width && tick_q && !ir_s_q && ld_cnt_q < HIGH_T
    |=> rep_q && state_q == irx_pkg::wait_leader_fall)
    else $error("short leader high not treated as repeat");
  meas_masked_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state_q != irx_pkg::receive_frame_bits |-> !meas_en_q)
    else $error("width capture enabled outside frame reception");
  tick_spacing_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tick_q |=> !tick_q [*8])
    else $error("sampling ticks too close");
  bit_lsb_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    meas_en_q && wif.bit_vld |=> frame_q[31] == $past(wif.bit_val))
    else $error("received bit not shifted in at top");
  frame_end_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    meas_en_q && last_bit |=> frame_vld_q && !meas_en_q && state_q == irx_pkg::wait_leader_fall)
    else $error("frame end handling wrong");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    |(status_q & mask_q) |=> irq_q || $past(st_clr) != '0)
    else $error("interrupt not raised for unmasked status");
  frame_cov: cover property (@(posedge clk_sys) frame_vld_q);
  repeat_cov: cover property (@(posedge clk_sys) rep_q);
  apb_err_cov: cover property (@(posedge clk_sys) pready_q && pslverr_q);

endmodule : ir_pulse_distance_receiver

// ### src/irx_pkg.sv
// Purpose: Shared constants and types of the infrared frame receiver.
// Assumes: clk_sys at 100 MHz.
// Notes:   Times are kept in their own unit; cycle and tick counts derive from them.
package irx_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS       = 10;
  localparam int TICK_PERIOD_NS      = 100000;
  localparam int TICK_CYCLES         = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_US             = TICK_PERIOD_NS / 1000;
  localparam int LEADER_LOW_MIN_US   = 7000;
  localparam int LEADER_HIGH_MIN_US  = 3000;
  localparam int LEADER_HIGH_MAX_US  = 6000;
  localparam int FRAME_TIMEOUT_US    = 120000;
  localparam int BIT_THRESH_NS       = 1000000;
  localparam int BIT_THRESH_CYCLES   = BIT_THRESH_NS / CLK_PERIOD_NS;

  // Tick counts; least times round up, longest times round down
  localparam int LOW_TICKS           = (LEADER_LOW_MIN_US + TICK_US - 1) / TICK_US;
  localparam int HIGH_TICKS          = (LEADER_HIGH_MIN_US + TICK_US - 1) / TICK_US;
  localparam int HIGH_MAX_TICKS      = LEADER_HIGH_MAX_US / TICK_US;
  localparam int TIMEOUT_TICKS       = FRAME_TIMEOUT_US / TICK_US;
  localparam int LD_CNT_W            = 11;
  localparam int FRAME_BITS          = 32;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_ADDR_CODE = 8'h04;
  localparam logic [7:0] OFS_CMD_CODES = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;
  localparam logic [7:0] OFS_FRAME     = 8'h14;
  localparam logic [7:0] OFS_STATE     = 8'h18;

  // Fields and reset values
  localparam int CTRL_TICK_RUN   = 0;
  localparam int ST_ACCEPT       = 0;
  localparam int ST_REPEAT       = 1;
  localparam int ST_REJECT       = 2;
  localparam int ST_TIMEOUT      = 3;
  localparam int ST_W            = 4;
  localparam logic [15:0] ADDR_CODE_RST = 16'h0000;
  localparam logic [7:0]  CMD_A_RST     = 8'h5A;
  localparam logic [7:0]  CMD_B_RST     = 8'hDA;

  // Levels
  localparam logic [7:0] LEVEL_OFF  = 8'h00;
  localparam logic [7:0] LEVEL_LOW  = 8'h55;
  localparam logic [7:0] LEVEL_MID  = 8'hAA;
  localparam logic [7:0] LEVEL_MAX  = 8'hFF;
  localparam logic [2:0] STEP_LAST  = 3'h5;

  typedef enum logic [1:0] {
    wait_leader_fall         = 2'b00,
    wait_leader_rise         = 2'b01,
    check_leader_high_width  = 2'b10,
    receive_frame_bits       = 2'b11
  } leader_state_t;

  typedef enum logic [1:0] {
    last_none = 2'b00,
    last_a    = 2'b01,
    last_b    = 2'b10
  } last_cmd_t;

endpackage : irx_pkg

// ### src/width_if.sv
// Purpose: Carrier between the frame control and the width measurement channel.
// Assumes: One clock domain.
// Notes:   Edges are one-cycle pulses from synchronised input.
interface width_if #(parameter int WIDTH_W = 20);
  logic               en;
  logic               rise;
  logic               fall;
  logic               bit_vld;
  logic               bit_val;
  logic [WIDTH_W-1:0] width;

  modport meter (input en, input rise, input fall, output bit_vld, output bit_val, output width);
  modport ctrl  (output en, output rise, output fall, input bit_vld, input bit_val, input width);
endinterface : width_if

// ### src/width_meter.sv
// Purpose: High-level width measurement and bit classification.
// Assumes: Edge pulses come from synchronised input.
// Notes:   Counter saturates; a pulse longer than the range reads as one.
module width_meter #(
  parameter int WIDTH_W           = 20,
  parameter int BIT_THRESH_CYCLES = irx_pkg::BIT_THRESH_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  width_if.meter    wif
);
  localparam logic [WIDTH_W-1:0] THRESH  = WIDTH_W'(BIT_THRESH_CYCLES);
  localparam logic [WIDTH_W-1:0] CNT_MAX = '1;

  logic [WIDTH_W-1:0] cnt_q;
  logic               run_q;
  logic               vld_q;
  logic               val_q;
  logic [WIDTH_W-1:0] width_q;

  wire               start   = wif.en && wif.rise;
  wire               capture = wif.en && run_q && wif.fall;
  wire [WIDTH_W-1:0] cnt_inc = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 1'b1;

  // Start on rise, capture on fall
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (!wif.en) begin
      run_q <= 1'b0;
    end else if (start) begin
      cnt_q <= '0;
      run_q <= 1'b1;
    end else if (capture) begin
      run_q <= 1'b0;
    end else if (run_q) begin
      cnt_q <= cnt_inc;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      vld_q   <= 1'b0;
      val_q   <= 1'b0;
      width_q <= '0;
    end else begin
      vld_q <= capture;
      if (capture) begin
        val_q   <= (cnt_q > THRESH);
        width_q <= cnt_q;
      end
    end
  end

  assign wif.bit_vld = vld_q;
  assign wif.bit_val = val_q;
  assign wif.width   = width_q;

  bit_class_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    capture && (cnt_q > THRESH) |=> wif.bit_vld && wif.bit_val)
    else $error("long high width not classified as one");
  width_start_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    start |=> run_q && (cnt_q == '0))
    else $error("width counter did not start on rising edge");

endmodule : width_meter

// ### verif/ir_remote_model.sv
// Purpose: Behavioural IR remote driving the receiver input pin.
// Assumes: Idle level high; all times in clk_sys cycles.
// Notes:   Bit widths straddle a threshold of 40 cycles.
module ir_remote_model (
  input  wire logic clk_sys,
  output logic      ir_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  initial ir_pin = 1'b1;

  task automatic hold(input logic v, input int n);
    ir_pin <= v;
    repeat (n) @(posedge clk_sys);
  endtask : hold

  // Leader, then 32 bits unless the high part is a repeat
  task automatic send(input logic [31:0] f, input int low, input int high);
    hold(1'b0, low);
    hold(1'b1, high);
    hold(1'b0, 50);
    for (int i = 0; i < 32 && high > 600; i++) begin
      hold(1'b1, f[i] ? 60 : 20);
      hold(1'b0, 12);
    end
    hold(1'b1, 100);
  endtask : send
endmodule : ir_remote_model

// ### verif/testbench.sv
// Purpose: Self-checking bench of the IR frame receiver.
// Assumes: Tick of 20 cycles, bit threshold of 40 cycles.
// Notes:   Reads and level changes are matched against queued notes.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} rd_t;
  logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, ir_pin, irq;
  logic [7:0]  paddr, lvl_a, lvl_b, lvl_c, prev, ev;
  logic [31:0] pwdata, prdata, rnd, fr;
  rd_t         e;
  rd_t         rq[$];
  logic [7:0]  lq[$];
  int          error_cnt, checked, cyc;
  logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
  logic [7:0]  steps[6] = '{8'h55, 8'hAA, 8'hFF, 8'hAA, 8'h55, 8'h00};

  ir_pulse_distance_receiver #(.TICK_CYCLES(20), .BIT_THRESH_CYCLES(40), .WIDTH_W(8)) u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ir_input_pin(ir_pin), .irq(irq), .led_level_a(lvl_a), .led_level_b(lvl_b),
    .led_level_c(lvl_c));
  ir_remote_model u_rem (.clk_sys(clk_sys), .ir_pin(ir_pin));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    rq.push_back('{d, m, a > 8'h18});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic tx(input logic [31:0] f, input int low, input int high, input int lv);
    if (lv >= 0) lq.push_back(8'(lv));
    u_rem.send(f, low, high);
    repeat (20) @(posedge clk_sys);
  endtask : tx

  task automatic irq_is(input logic v);
    checked++;
    if (irq !== v) begin
      error_cnt++;
      $display("unexpected %0t irq level", $time);
    end
  endtask : irq_is

  task automatic wrap_up();
    $display("errors %0d checked %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (rst_b && psel && penable && pready === 1'b1 && !pwrite) begin
      e = rq.pop_front();
      checked++;
      if ((prdata & e.m) !== (e.d & e.m) || pslverr !== e.e) begin
        error_cnt++;
        $display("unexpected %0t read %h at %h", $time, prdata, paddr);
      end
    end
    if (rst_b && lvl_a !== prev) begin
      prev = lvl_a;
      ev = (lq.size() > 0) ? lq.pop_front() : ~lvl_a;
      checked++;
      if (lvl_a !== ev || lvl_b !== ev || lvl_c !== ev) begin
        error_cnt++;
        $display("unexpected %0t level %h", $time, lvl_a);
      end
    end
    if (cyc == 95000) begin
      error_cnt++;
      $display("unexpected %0t timeout", $time);
      wrap_up();
    end
  end

  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    prev = 8'h00;
    rnd  = 32'h117C0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 6; i++) rd(ra[i], (i == 2) ? 32'hDA5A : 32'h0, 32'hFFFFFFFF);
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b1, 8'h00, 32'h1);
    fr = {8'hA5, 8'h5A, 16'h0000};
    tx(fr, 1500, 800, 85);
    rd(8'h0C, 32'h1, 32'hF);
    irq_is(1'b1);
    apb(1'b1, 8'h0C, 32'hF);
    rd(8'h0C, 32'h0, 32'hF);
    irq_is(1'b0);
    for (int i = 1; i < 6; i++) tx(fr, 1500, 800, steps[i]);
    tx(fr, 1500, 300, 85);
    rd(8'h0C, 32'h2, 32'h2);
    apb(1'b1, 8'h0C, 32'hF);
    tx(fr, 1200, 800, -1);
    rd(8'h0C, 32'h0, 32'h1);
    rnd = xs(rnd);
    fr  = {8'hA5, 8'h5A, rnd[15:0] | 16'h1};
    tx(fr, 1500, 800, -1);
    rd(8'h0C, 32'h4, 32'h4);
    apb(1'b1, 8'h04, {16'h0, fr[15:0]});
    tx(fr, 1500, 800, 170);
    rd(8'h14, fr, 32'hFFFFFFFF);
    fr = {8'h25, 8'hDA, fr[15:0]};
    tx(fr, 1500, 800, 0);
    tx(fr, 1500, 800, 255);
    tx(fr, 1500, 300, 0);
    apb(1'b1, 8'h0C, 32'hF);
    u_rem.hold(1'b0, 1500);
    u_rem.hold(1'b1, 800);
    u_rem.hold(1'b0, 50);
    u_rem.hold(1'b1, 100);
    repeat (24500) @(posedge clk_sys);
    rd(8'h0C, 32'h8, 32'hF);
    rd(8'h18, 32'h0, 32'h70FF);
    checked++;
    if (rq.size() != 0 || lq.size() != 0) begin
      error_cnt++;
      $display("unexpected %0t results missing", $time);
    end
    wrap_up();
  end
endmodule : testbench
